/* File: inc/scg_pkg.sv */
// Purpose: constants for the system configuration guard register bank
// Assumes: apb, 32-bit data, word-aligned registers
// Notes: offsets are local choices
package scg_pkg;
    localparam logic [11:0] SCG_OFF_GUARD = 12'h000;
    localparam logic [11:0] SCG_OFF_RAM = 12'h004;
    localparam logic [11:0] SCG_OFF_FLASH = 12'h008;
    localparam logic [15:0] SCG_UNLOCK_KEY = 16'h0096;
    localparam logic [15:0] SCG_GUARD_RESET = 16'h0000;
    localparam logic [2:0] SCG_RAM_RESET = 3'h6;
    localparam logic [1:0] SCG_FLASH_RESET = 2'h1;
    localparam logic [4:0] SCG_RAM_FIXED = 5'h0c;
    localparam int SCG_RAM_LSB = 0;
    localparam int SCG_RAM_FIXED_LSB = 3;
    localparam int SCG_RSV_BIT = 8;
    localparam logic [2:0] SCG_RAM_RESERVED = 3'h7;
    localparam logic [15:0] SCG_RAM_512B = 16'h0200;
    localparam logic [2:0] SCG_RAM_SEL_12K = 3'h5;
    localparam logic [2:0] SCG_RAM_SEL_16K = 3'h6;
    localparam logic [15:0] SCG_RAM_12KB = 16'h3000;
    localparam logic [15:0] SCG_RAM_16KB = 16'h4000;
    localparam logic [15:0] SCG_RAM_NONE = 16'h0000;
    localparam logic [2:0] SCG_FLASH_CYC_STEP = 3'h1;
    localparam logic [2:0] SCG_FLASH_CYC_RESET = 3'h2;
endpackage

/* File: verification/scg_regs_test.sv */
// Purpose: self-checking bench for the guarded configuration register bank
// Assumes: apb slave, read data taken at the completing edge
// Notes: no random stimulus; rows cover every ram and flash code
`timescale 1ns/1ps
module scg_regs_test;
    import scg_pkg::*;
    typedef struct packed {logic [2:0] sel; logic [1:0] fc; logic [15:0] bytes;} scg_row_t;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, rd;
    logic [3:0] pstrb = 4'h3;
    logic [3:0] strb = 4'h3;
    logic [31:0] prdata;
    logic pready, pslverr, ram_size_reserved, unlocked, er;
    logic [2:0] ram_size_select, flash_access_cycles;
    logic [1:0] flash_cycle_count;
    logic [15:0] ram_size_bytes;
    int err_total = 0, cmp_count = 0;
    scg_row_t rows [8] = '{'{3'h0, 2'h0, 16'h0200}, '{3'h1, 2'h1, 16'h0400},
        '{3'h2, 2'h2, 16'h0800}, '{3'h3, 2'h3, 16'h1000}, '{3'h4, 2'h0, 16'h2000},
        '{3'h5, 2'h1, 16'h3000}, '{3'h6, 2'h2, 16'h4000}, '{3'h7, 2'h3, 16'h0000}};
    scg_regs scg_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ram_size_select(ram_size_select),
        .flash_cycle_count(flash_cycle_count), .flash_access_cycles(flash_access_cycles),
        .ram_size_bytes(ram_size_bytes), .ram_size_reserved(ram_size_reserved),
        .unlocked(unlocked));
    initial begin
        forever #12.5 pclk = ~pclk;
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            err_total++;
        end
    endtask
    // one transfer; read data and error stand through the access phase and are
    // taken at the completing edge, before that edge's own updates land
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= strb;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // outputs are looked at mid-cycle, after the write has landed
        @(negedge pclk);
    endtask
    initial begin
        repeat (3000) @(posedge pclk);
        err_total++;
        stop_test();
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, SCG_OFF_GUARD, 0);
        chk("guard init", 32'h0000_0000, rd);
        apb(0, SCG_OFF_RAM, 0);
        chk("ram init", 32'h0000_0066, rd);
        apb(0, SCG_OFF_FLASH, 0);
        chk("flash init", 32'h0000_0001, rd);
        chk("cycles init", 32'h0000_0002, 32'(flash_access_cycles));
        chk("size init", 32'h0000_4000, 32'(ram_size_bytes));
        apb(1, SCG_OFF_RAM, 32'h0000_0002);
        chk("locked ram", 32'(3'h6), 32'(ram_size_select));
        // a flash cycle write while still locked must be dropped, with no error
        apb(1, SCG_OFF_FLASH, 32'h0000_0003);
        chk("locked flash", 32'(2'h1), 32'(flash_cycle_count));
        chk("locked err", 32'(1'b0), 32'(er));
        apb(1, SCG_OFF_GUARD, 32'h0000_0096);
        chk("unlock", 32'(1'b1), 32'(unlocked));
        for (int i = 0; i < 8; i++) begin
            apb(1, SCG_OFF_RAM, 32'(rows[i].sel));
            apb(1, SCG_OFF_FLASH, 32'(rows[i].fc));
            apb(0, SCG_OFF_RAM, 0);
            chk("ram read", 32'h60 | 32'(rows[i].sel), rd);
            chk("ram bytes", 32'(rows[i].bytes), 32'(ram_size_bytes));
            chk("ram rsv", 32'(rows[i].sel == 3'h7), 32'(ram_size_reserved));
            chk("flash cyc", 32'(rows[i].fc) + 1, 32'(flash_access_cycles));
            apb(0, SCG_OFF_FLASH, 0);
            chk("flash read", 32'(rows[i].fc), rd);
        end
        // high byte only: the selector must keep its value
        strb = 4'h2;
        apb(1, SCG_OFF_RAM, 32'h0000_0001);
        strb = 4'h3;
        apb(0, SCG_OFF_RAM, 0);
        chk("strobe ram", 32'h0000_0067, rd);
        // one digit off the key must lock again
        apb(1, SCG_OFF_GUARD, 32'h0000_0095);
        chk("relock", 32'(1'b0), 32'(unlocked));
        apb(1, SCG_OFF_RAM, 32'h0000_0001);
        apb(0, SCG_OFF_RAM, 0);
        chk("relock ram", 32'h0000_0067, rd);
        apb(0, 12'h00c, 0);
        chk("unmapped err", 32'(1'b1), 32'(er));
        chk("unmapped data", 32'h0000_0000, rd);
        chk("ready idle", 32'(1'b0), 32'(pready));
        apb(1, SCG_OFF_GUARD, 32'h0000_0096);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk("reset relock", 32'(1'b0), 32'(unlocked));
        chk("reset ram", 32'(3'h6), 32'(ram_size_select));
        chk("reset cycles", 32'h0000_0002, 32'(flash_access_cycles));
        apb(0, SCG_OFF_FLASH, 0);
        chk("reset flash", 32'h0000_0001, rd);
        chk("reset err", 32'(1'b0), 32'(er));
        stop_test();
    end
endmodule

/* File: verilog/scg_regs.sv */
// Purpose: apb register bank holding the write guard, ram size and flash cycles
// Assumes: single clock, apb slave answers with zero wait states
// Notes: unmapped addresses read zero and raise pslverr
`timescale 1ns/1ps
// What this block does
// - guard key equal to 0x0096 unlocks; any other value keeps protection on.
// - while protected, writes to protected bits are discarded, values unchanged.
// - ram size selector and flash cycle setting are protected fields.
// - ram size selector decodes 512B up to 16KB; 0x7 reserved.
// - flash cycle field 0..3 gives 1..4 bus access cycles.
// - unlock persists until a non-key value is written back.
module scg_regs
    import scg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [2:0] ram_size_select,
    output logic [1:0] flash_cycle_count,
    output logic [2:0] flash_access_cycles,
    output logic [15:0] ram_size_bytes,
    output logic ram_size_reserved,
    output logic unlocked
);
    typedef struct packed {
        logic [15:0] guard_key;
        logic [2:0] ram_sel;
        logic ram_rsv;
        logic [1:0] flash_cnt;
        logic flash_rsv;
        logic [31:0] rdata;
        logic err;
        logic [15:0] size_bytes;
        logic size_rsv;
        logic unlock;
        logic [2:0] flash_cyc;
        logic ready;
    } scg_state_t;

    scg_state_t state_reg;
    scg_state_t state_next;
    logic [15:0] dec_bytes;
    logic dec_rsv;
    logic setup;
    logic access;
    logic wr;
    logic open_guard;
    logic [15:0] wlo;

    // ready is registered too: the slave answers in the first access cycle;
    // a master that skips the setup cycle gets no answer and no write
    assign setup = psel && !penable;
    assign access = psel && penable && state_reg.ready;
    assign wr = access && pwrite;
    assign open_guard = (state_reg.guard_key == SCG_UNLOCK_KEY);
    assign wlo = {pstrb[1] ? pwdata[15:8] : 8'h00, pstrb[0] ? pwdata[7:0] : 8'h00};

    scg_size_decode u_dec (
        .sel(state_next.ram_sel),
        .size_kb_bytes(dec_bytes),
        .reserved(dec_rsv)
    );

    always_comb begin
        state_next = state_reg;
        // read data and error launch at the setup edge so they stand for the
        // whole access phase; they fall back to zero after the completing edge
        state_next.rdata = 32'h0000_0000;
        state_next.err = 1'b0;
        state_next.ready = setup;
        if (setup) begin
            case (paddr)
                SCG_OFF_GUARD: begin
                    state_next.rdata = {16'h0000, state_reg.guard_key};
                end
                SCG_OFF_RAM: begin
                    state_next.rdata = {23'h00_0000, state_reg.ram_rsv,
                        SCG_RAM_FIXED, state_reg.ram_sel};
                end
                SCG_OFF_FLASH: begin
                    state_next.rdata = {23'h00_0000, state_reg.flash_rsv,
                        6'h00, state_reg.flash_cnt};
                end
                default: begin
                    // unmapped: reads zero, flagged, and any write is dropped
                    state_next.err = 1'b1;
                end
            endcase
        end
        if (wr) begin
            case (paddr)
                SCG_OFF_GUARD: begin
                    // guard itself is never protected, so it can always relock
                    if (pstrb[0]) state_next.guard_key[7:0] = pwdata[7:0];
                    if (pstrb[1]) state_next.guard_key[15:8] = pwdata[15:8];
                end
                SCG_OFF_RAM: begin
                    if (open_guard) begin
                        if (pstrb[0]) state_next.ram_sel = wlo[2:0];
                        if (pstrb[1]) state_next.ram_rsv = wlo[SCG_RSV_BIT];
                    end
                end
                SCG_OFF_FLASH: begin
                    if (open_guard) begin
                        if (pstrb[0]) state_next.flash_cnt = wlo[1:0];
                        if (pstrb[1]) state_next.flash_rsv = wlo[SCG_RSV_BIT];
                    end
                end
                default: begin
                    state_next.rdata = 32'h0000_0000;
                end
            endcase
        end
        state_next.size_bytes = dec_bytes;
        state_next.size_rsv = dec_rsv;
        // decoded outputs come from flops, built from the next state
        state_next.unlock = (state_next.guard_key == SCG_UNLOCK_KEY);
        state_next.flash_cyc = {1'b0, state_next.flash_cnt} + SCG_FLASH_CYC_STEP;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '{guard_key: SCG_GUARD_RESET, ram_sel: SCG_RAM_RESET,
                ram_rsv: 1'b0, flash_cnt: SCG_FLASH_RESET, flash_rsv: 1'b0,
                rdata: 32'h0000_0000, err: 1'b0, size_bytes: SCG_RAM_16KB,
                size_rsv: 1'b0, unlock: 1'b0, flash_cyc: SCG_FLASH_CYC_RESET,
                ready: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign prdata = state_reg.rdata;
    assign pready = state_reg.ready;
    assign pslverr = state_reg.err;
    assign ram_size_select = state_reg.ram_sel;
    assign flash_cycle_count = state_reg.flash_cnt;
    assign flash_access_cycles = state_reg.flash_cyc;
    assign ram_size_bytes = state_reg.size_bytes;
    assign ram_size_reserved = state_reg.size_rsv;
    assign unlocked = state_reg.unlock;

    property p_locked_ram;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == SCG_OFF_RAM && !open_guard) |=> $stable(ram_size_select);
    endproperty
    AST_LOCKED_RAM: assert property (p_locked_ram) else $error("ram size changed while locked");
    AST_LOCKED_FLASH: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && paddr == SCG_OFF_FLASH && !open_guard) |=> $stable(flash_cycle_count))
        else $error("flash cycles changed while locked");
    AST_UNLOCK: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && paddr == SCG_OFF_GUARD && pstrb[1:0] == 2'b11 && pwdata[15:0] == SCG_UNLOCK_KEY)
        |=> unlocked)
        else $error("key did not unlock");
    sequence s_unlocked_ram_write;
        wr && paddr == SCG_OFF_RAM && open_guard && pstrb[0];
    endsequence
    AST_OPEN_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        s_unlocked_ram_write |=> ram_size_select == $past(pwdata[2:0]))
        else $error("unlocked write lost");
    AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        (unlocked && !(wr && paddr == SCG_OFF_GUARD)) |=> unlocked)
        else $error("unlock dropped without relock");
    AST_CYCLES: assert property (@(posedge pclk) disable iff (!presetn)
        flash_access_cycles == 3'(flash_cycle_count) + 3'h1)
        else $error("flash cycles decode wrong");
    AST_SIZE: assert property (@(posedge pclk) disable iff (!presetn)
        (ram_size_select == 3'h5) |-> ram_size_bytes == 16'h3000)
        else $error("12KB decode wrong");
    AST_RSV: assert property (@(posedge pclk) disable iff (!presetn)
        ram_size_reserved == (ram_size_select == SCG_RAM_RESERVED))
        else $error("reserved decode wrong");

    // bus handshake: the answer comes in the first access cycle only
    sequence s_setup_phase;
        psel && !penable;
    endsequence
    sequence s_unmapped_setup;
        psel && !penable && paddr != SCG_OFF_GUARD && paddr != SCG_OFF_RAM
            && paddr != SCG_OFF_FLASH;
    endsequence
    sequence s_guard_read_setup;
        psel && !penable && !pwrite && paddr == SCG_OFF_GUARD;
    endsequence
    sequence s_unlocked_flash_write;
        wr && paddr == SCG_OFF_FLASH && open_guard && pstrb[0];
    endsequence
    sequence s_guard_relock;
        wr && paddr == SCG_OFF_GUARD && pstrb[1:0] == 2'b11
            && pwdata[15:0] != SCG_UNLOCK_KEY;
    endsequence
    AST_READY_ACCESS: assert property (@(posedge pclk) disable iff (!presetn)
        s_setup_phase |=> pready)
        else $error("no ready in access phase");
    AST_READY_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
        !(psel && !penable) |=> !pready)
        else $error("ready outside access phase");
    AST_UNMAPPED_ERR: assert property (@(posedge pclk) disable iff (!presetn)
        s_unmapped_setup |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not flagged");
    // unlock and readback are both taken from the guard at the setup edge,
    // so a readback equal to the key must come with the unlocked flag
    AST_GUARD_READ: assert property (@(posedge pclk) disable iff (!presetn)
        s_guard_read_setup |=> (prdata[15:0] == SCG_UNLOCK_KEY) == unlocked)
        else $error("guard readback and unlock disagree");
    AST_OPEN_FLASH: assert property (@(posedge pclk) disable iff (!presetn)
        s_unlocked_flash_write |=> flash_cycle_count == $past(pwdata[1:0]))
        else $error("unlocked flash write lost");
    // a full-width non-key value must close the guard at once
    AST_RELOCK: assert property (@(posedge pclk) disable iff (!presetn)
        s_guard_relock |=> !unlocked)
        else $error("wrong key left the guard open");
endmodule

/* File: verilog/scg_size_decode.sv */
// Purpose: decode the ram size selector into a byte count and a reserved flag
// Assumes: selector is the unregistered next-state value; the caller registers the outputs
// Notes: 0x5 gives 12KB, not a power of two
`timescale 1ns/1ps
module scg_size_decode
    import scg_pkg::*;
(
    input wire logic [2:0] sel,
    output logic [15:0] size_kb_bytes,
    output logic reserved
);
    always_comb begin
        reserved = (sel == SCG_RAM_RESERVED);
        case (sel)
            SCG_RAM_SEL_12K: size_kb_bytes = SCG_RAM_12KB;
            SCG_RAM_SEL_16K: size_kb_bytes = SCG_RAM_16KB;
            SCG_RAM_RESERVED: size_kb_bytes = SCG_RAM_NONE;
            default: size_kb_bytes = 16'(SCG_RAM_512B << sel);
        endcase
    end
endmodule
